// >>> design/core_pipe_consts.vh
// Shared constants of the five-stage core pipeline.
// Assumes inclusion by bare name; definitions only.
`ifndef CORE_PIPE_CONSTS_VH
`define CORE_PIPE_CONSTS_VH
// Product/quotient unit build styles
`define PQ_STYLE_FULL 2'd0
`define PQ_STYLE_FAST 2'd1
`define PQ_STYLE_SMALL 2'd2
// Instruction set builds
`define ISA_STD_ONLY 2'd0
`define ISA_BOTH 2'd1
`define ISA_COMPACT_ONLY 2'd2
// Stall counts held in the memory stage
`define FAST_MUL32_STALL 6'd1
`define SMALL_MUL_STALL 6'd31
`define SMALL_MAC_STALL 6'd33
`define DIV_MAX_STALL 6'd38
`define DIV_SKIP_8 6'd23
`define DIV_SKIP_16 6'd15
`define DIV_SKIP_24 6'd7
// Internal operation codes
`define OP_ADD 4'h0
`define OP_SUB 4'h1
`define OP_AND 4'h2
`define OP_OR 4'h3
`define OP_XOR 4'h4
`define OP_SLL 4'h5
`define OP_SRL 4'h6
`define OP_LOAD 4'h7
`define OP_STORE 4'h8
`define OP_BEQ 4'h9
`define OP_MUL 4'ha
`define OP_MULT 4'hb
`define OP_MADD 4'hc
`define OP_DIV 4'hd
`define OP_MFHI 4'he
`define OP_MFLO 4'hf
// Fixed mapping: top address bits cleared for kernel segments
`define MAP_MASK 32'h1fff_ffff
`endif

// >>> design/general_register_file.v
// General register file with 1, 3, 7 or 15 shadow sets.
// Assumes one clock; two reads, one write, write-through bypass.
`timescale 1ns/1ps
module general_register_file #(
    parameter SET_BITS = 0
) (
    input wire core_clk,
    input wire [SET_BITS:0] set_sel,
    input wire [4:0] rd_a_addr,
    input wire [4:0] rd_b_addr,
    output wire [31:0] rd_a_data,
    output wire [31:0] rd_b_data,
    input wire wr_en,
    input wire [4:0] wr_addr,
    input wire [31:0] wr_data
);
    // Select width SET_BITS+1 gives 2, 4, 8 or 16 sets (1, 3, 7 or 15 shadows)
    localparam SETS = 2 << SET_BITS;
    reg [31:0] regs [0:SETS*32-1];
    wire [SET_BITS+5:0] a_idx = {set_sel, rd_a_addr};
    wire [SET_BITS+5:0] b_idx = {set_sel, rd_b_addr};
    wire [SET_BITS+5:0] w_idx = {set_sel, wr_addr};

    // Register zero never written; one write port
    always @(posedge core_clk) begin
        if (wr_en && wr_addr != 5'h00) begin
            regs[w_idx] <= wr_data;
        end
    end

    // Two read ports, bypassed from the write port
    assign rd_a_data = (rd_a_addr == 5'h00) ? 32'h0000_0000 :
        (wr_en && wr_addr == rd_a_addr) ? wr_data : regs[a_idx];
    assign rd_b_data = (rd_b_addr == 5'h00) ? 32'h0000_0000 :
        (wr_en && wr_addr == rd_b_addr) ? wr_data : regs[b_idx];
endmodule

// >>> design/product_quotient_unit.v
// Product/quotient unit beside the integer pipeline.
// Assumes launch pulses from execute; holds upper/lower product registers.
`include "core_pipe_consts.vh"
`timescale 1ns/1ps
module product_quotient_unit #(
    parameter STYLE = 1
) (
    input wire core_clk,
    input wire rst_n,
    input wire launch,
    input wire [3:0] op,
    input wire [31:0] src_a,
    input wire [31:0] src_b,
    output wire busy,
    output reg [31:0] upper_product_register,
    output reg [31:0] lower_product_register,
    output reg gpr_result_valid,
    output reg [31:0] gpr_result
);
    localparam S_IDLE = 3'b001;
    localparam S_HOLD = 3'b010;
    localparam S_ALIGN = 3'b100;
    reg [2:0] state;
    reg [5:0] count;
    reg [3:0] held_op;
    reg [63:0] result;
    reg [5:0] next_count;
    wire [63:0] prod = src_a * src_b;
    wire [63:0] acc = {upper_product_register, lower_product_register} + prod;
    wire [31:0] quo = (src_b == 32'h0) ? 32'hffff_ffff : src_a / src_b;
    wire [31:0] rem = (src_b == 32'h0) ? src_a : src_a % src_b;
    wire a_sx8 = (src_a[31:8] == {24{src_a[7]}});
    wire a_sx16 = (src_a[31:16] == {16{src_a[15]}});
    wire a_sx24 = (src_a[31:24] == {8{src_a[23]}});
    wire mul_small_b = (src_b[31:16] == {16{src_b[15]}});

    // Stall length chosen by build style and operation
    always @* begin
        next_count = 6'd0;
        if (op == `OP_DIV) begin
            next_count = `DIV_MAX_STALL;
            if (STYLE == `PQ_STYLE_FAST) begin
                if (a_sx8) next_count = `DIV_MAX_STALL - `DIV_SKIP_8;
                else if (a_sx16) next_count = `DIV_MAX_STALL - `DIV_SKIP_16;
                else if (a_sx24) next_count = `DIV_MAX_STALL - `DIV_SKIP_24;
            end
        end else if (STYLE == `PQ_STYLE_SMALL) begin
            next_count = (op == `OP_MADD) ? `SMALL_MAC_STALL : `SMALL_MUL_STALL;
        end else if (STYLE == `PQ_STYLE_FAST && !mul_small_b) begin
            next_count = `FAST_MUL32_STALL;
        end
        // Full array finishes in the memory stage with no hold
    end

    assign busy = (state != S_IDLE);

    // Launch, hold in memory stage, then commit in align
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            count <= 6'd0;
            held_op <= 4'h0;
            result <= 64'h0;
            upper_product_register <= 32'h0;
            lower_product_register <= 32'h0;
            gpr_result_valid <= 1'b0;
            gpr_result <= 32'h0;
        end else begin
            gpr_result_valid <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (launch) begin
                        held_op <= op;
                        count <= next_count;
                        if (op == `OP_DIV) result <= {rem, quo};
                        else if (op == `OP_MADD) result <= acc;
                        else result <= prod;
                        state <= (next_count == 6'd0) ? S_ALIGN : S_HOLD;
                    end
                end
                S_HOLD: begin
                    count <= count - 6'd1;
                    if (count == 6'd1) state <= S_ALIGN;
                end
                S_ALIGN: begin
                    // Carry-propagate result committed in align
                    if (held_op == `OP_MUL) begin
                        gpr_result_valid <= 1'b1;
                        gpr_result <= result[31:0];
                    end else begin
                        upper_product_register <= result[63:32];
                        lower_product_register <= result[31:0];
                    end
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule

// >>> design/five_stage_core_pipeline.v
// Five-stage integer pipeline: fetch, execute, memory, align, writeback.
// Assumes single-cycle instruction and data SRAMs, answer next clock.
//
// Summary of operation
// - Fetch, execute, memory, align, writeback; one stage per clock.
// - Memory and align results bypass into execute operands.
// - Fetch reads one instruction; compact forms translated when both sets built.
// - Compact-only build expands 16-bit forms to 32-bit compact first.
// - Execute reads operands, starts ALU, forms and maps addresses.
// - Execute resolves branch condition and target.
// - Multiply and divide launch in execute.
// - Memory stage completes ALU and performs data SRAM access.
// - Full array build finishes 32x32 multiply with no stall.
// - Fast build holds 32x32 multiply one extra clock.
// - Small build holds multiply 31 clocks.
// - Small build holds multiply-accumulate 33 clocks.
// - Divide holds at most 38 clocks.
// - Only fast build skips 7, 15 or 23 divide clocks.
// - Align stage aligns load data before writeback.
// - Small build writes upper/lower product registers in align.
// - Multiply-accumulate adds at launch; upper/lower registers committed in align.
// - Register-target multiply presents result at align, writes in writeback.
// - Break compare of memory-stage result against break_value evaluated in align.
// - Register and load results written in writeback.
// - Simple ALU ops single cycle; product unit runs alongside.
// - Thirty-two 32-bit registers, plus 1, 3, 7 or 15 shadow sets.
// - Two read ports, one write port, fully bypassed.
`include "core_pipe_consts.vh"
`timescale 1ns/1ps
module five_stage_core_pipeline #(
    parameter PQ_STYLE = 1,
    parameter ISA_MODE = 1,
    parameter SHADOW_BITS = 0,
    parameter [31:0] RESET_PC = 32'h0000_0000
) (
    input wire core_clk,
    input wire reset_n,
    input wire [SHADOW_BITS:0] shadow_set,
    output reg [31:0] instr_addr,
    output wire instr_req,
    input wire [31:0] instr_rdata,
    output reg [31:0] data_addr,
    output reg data_req,
    output reg data_we,
    output reg [31:0] data_wdata,
    input wire [31:0] data_rdata,
    input wire [31:0] break_value,
    input wire break_enable,
    output reg break_hit
);
    ////////////////////////////////////////////////////////////////////
    // Reset release
    reg rst_meta;
    reg rst_n;
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Fetch stage: decoding into internal form
    // Internal form: [31:28] op, [27:23] dst, [22:18] src a, [17:13] src b,
    // [12:0] signed immediate.
    reg [31:0] pc;
    reg half_sel;
    wire stall;
    wire redirect;
    wire [31:0] redirect_pc;
    reg f_valid;
    reg [31:0] f_pc;
    reg [31:0] held_word;
    reg held_full;
    // Word parked while stalled, so the answered fetch is not lost
    wire [31:0] fetch_word = held_full ? held_word : instr_rdata;
    wire [15:0] half = half_sel ? fetch_word[31:16] : fetch_word[15:0];
    wire is_compact16 = (ISA_MODE != `ISA_STD_ONLY) && half[15];
    reg [31:0] compact32;
    reg [31:0] decoded;

    // Expand 16-bit compact into 32-bit compact form
    always @* begin
        compact32 = {half[14:11], 1'b0, half[10:8], 1'b0, half[7:5],
            2'b00, half[4:2], 10'h000, half[1:0], 2'b00};
    end

    // Translate compact forms to internal layout
    always @* begin
        decoded = fetch_word;
        if (is_compact16) begin
            decoded = compact32;
        end
    end

    assign instr_req = rst_n;
    ////////////////////////////////////////////////////////////////////
    // Fetch to execute register and program counter
    reg e_valid;
    reg [31:0] e_ir;
    reg [31:0] e_pc;
    wire [31:0] next_pc_seq = pc + (is_compact16 ? 32'd2 : 32'd4);
    // One instruction read per clock, held on stall
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc <= RESET_PC;
            half_sel <= 1'b0;
            e_valid <= 1'b0;
            e_ir <= 32'h0;
            e_pc <= 32'h0;
            instr_addr <= RESET_PC & `MAP_MASK;
            f_valid <= 1'b0;
            f_pc <= RESET_PC;
            held_word <= 32'h0;
            held_full <= 1'b0;
        end else if (redirect) begin
            pc <= redirect_pc;
            half_sel <= redirect_pc[1];
            instr_addr <= {redirect_pc[31:2], 2'b00} & `MAP_MASK;
            e_valid <= 1'b0;
            f_valid <= 1'b0;
            held_full <= 1'b0;
        end else if (!stall) begin
            // Answer on the bus belongs to the address sent one clock earlier
            pc <= next_pc_seq;
            half_sel <= next_pc_seq[1];
            instr_addr <= {next_pc_seq[31:2], 2'b00} & `MAP_MASK;
            e_valid <= f_valid;
            e_ir <= decoded;
            e_pc <= f_pc;
            f_pc <= pc;
            f_valid <= 1'b1;
            held_full <= 1'b0;
        end else if (!held_full) begin
            held_word <= instr_rdata;
            held_full <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Execute stage
    wire [3:0] e_op = e_ir[31:28];
    wire [4:0] e_dst = e_ir[27:23];
    wire [4:0] e_sa = e_ir[22:18];
    wire [4:0] e_sb = e_ir[17:13];
    wire [31:0] e_imm = {{19{e_ir[12]}}, e_ir[12:0]};
    wire [31:0] rf_a;
    wire [31:0] rf_b;
    reg m_valid;
    reg m_wr;
    reg [4:0] m_dst;
    reg [3:0] m_op;
    reg [31:0] m_res;
    reg a_valid;
    reg a_wr;
    reg [4:0] a_dst;
    reg [3:0] a_op;
    reg [1:0] a_off;
    reg [31:0] a_res;
    reg w_wr;
    reg [4:0] w_dst;
    reg [31:0] w_res;
    wire pq_busy;
    wire pq_gpr_valid;
    wire [31:0] pq_gpr;
    wire [31:0] pq_upper;
    wire [31:0] pq_lower;
    wire [31:0] a_final;
    reg [4:0] mul_dst;
    reg mul_inflight;

    // Destination of a register-target multiply, pending until written
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mul_dst <= 5'h0;
            mul_inflight <= 1'b0;
        end else if (pq_gpr_valid) begin
            mul_inflight <= 1'b0;
        end else if (e_go && e_op == `OP_MUL) begin
            mul_dst <= e_dst;
            mul_inflight <= 1'b1;
        end
    end

    // Operand bypass from memory and align stages
    wire m_fwd_ok = m_valid && m_wr && m_op != `OP_LOAD;
    wire [31:0] op_a = (m_fwd_ok && m_dst == e_sa && e_sa != 5'h0) ? m_res :
        (a_valid && a_wr && a_dst == e_sa && e_sa != 5'h0) ? a_final : rf_a;
    wire [31:0] op_b = (m_fwd_ok && m_dst == e_sb && e_sb != 5'h0) ? m_res :
        (a_valid && a_wr && a_dst == e_sb && e_sb != 5'h0) ? a_final : rf_b;

    // Interlocks: load-use and product unit users
    wire e_is_pq = e_op == `OP_MUL || e_op == `OP_MULT || e_op == `OP_MADD ||
        e_op == `OP_DIV;
    wire e_reads_pq = e_op == `OP_MFHI || e_op == `OP_MFLO || e_op == `OP_MADD;
    wire load_use = m_valid && m_op == `OP_LOAD && m_wr &&
        (m_dst == e_sa || m_dst == e_sb) && m_dst != 5'h0;
    wire pq_wait = pq_busy && (e_is_pq || e_reads_pq);
    // A pending register multiply holds issue, so its writeback never collides
    assign stall = e_valid && (load_use || pq_wait || mul_inflight);

    // Single-cycle ALU and address formation
    reg [31:0] alu;
    always @* begin
        case (e_op)
            `OP_ADD: alu = op_a + op_b;
            `OP_SUB: alu = op_a - op_b;
            `OP_AND: alu = op_a & op_b;
            `OP_OR: alu = op_a | op_b;
            `OP_XOR: alu = op_a ^ op_b;
            `OP_SLL: alu = op_a << op_b[4:0];
            `OP_SRL: alu = op_a >> op_b[4:0];
            `OP_LOAD: alu = op_a + e_imm;
            `OP_STORE: alu = op_a + e_imm;
            `OP_MFHI: alu = pq_upper;
            `OP_MFLO: alu = pq_lower;
            default: alu = 32'h0;
        endcase
    end

    // Branch condition and target
    wire e_go = e_valid && !stall;
    assign redirect = e_go && e_op == `OP_BEQ && op_a == op_b;
    assign redirect_pc = e_pc + {e_imm[30:0], 1'b0};

    wire e_writes = e_op != `OP_STORE && e_op != `OP_BEQ && e_op != `OP_MULT &&
        e_op != `OP_MADD && e_op != `OP_DIV && e_op != `OP_MUL;

    ////////////////////////////////////////////////////////////////////
    // Memory stage: data access
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            m_valid <= 1'b0;
            m_wr <= 1'b0;
            m_dst <= 5'h0;
            m_op <= 4'h0;
            m_res <= 32'h0;
            data_req <= 1'b0;
            data_we <= 1'b0;
            data_addr <= 32'h0;
            data_wdata <= 32'h0;
        end else begin
            m_valid <= e_go;
            m_wr <= e_go && e_writes;
            m_dst <= e_dst;
            m_op <= e_op;
            m_res <= alu;
            data_req <= e_go && (e_op == `OP_LOAD || e_op == `OP_STORE);
            data_we <= e_go && e_op == `OP_STORE;
            data_addr <= alu & `MAP_MASK;
            data_wdata <= op_b;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Align stage: load alignment and break
    reg [31:0] aligned;
    always @* begin
        aligned = data_rdata >> {a_off, 3'b000};
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_valid <= 1'b0;
            a_wr <= 1'b0;
            a_dst <= 5'h0;
            a_op <= 4'h0;
            a_off <= 2'b00;
            a_res <= 32'h0;
            break_hit <= 1'b0;
        end else begin
            a_valid <= m_valid;
            a_wr <= m_wr;
            a_dst <= m_dst;
            a_op <= m_op;
            a_off <= data_addr[1:0];
            a_res <= m_res;
            break_hit <= break_enable && m_valid && m_res == break_value;
        end
    end
    assign a_final = (a_op == `OP_LOAD) ? aligned : a_res;

    ////////////////////////////////////////////////////////////////////
    // Writeback stage
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_wr <= 1'b0;
            w_dst <= 5'h0;
            w_res <= 32'h0;
        end else if (pq_gpr_valid) begin
            w_wr <= 1'b1;
            w_dst <= mul_dst;
            w_res <= pq_gpr;
        end else begin
            w_wr <= a_valid && a_wr;
            w_dst <= a_dst;
            w_res <= a_final;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register file and product unit
    general_register_file #(.SET_BITS(SHADOW_BITS)) regfile (
        .core_clk(core_clk),
        .set_sel(shadow_set),
        .rd_a_addr(e_sa),
        .rd_b_addr(e_sb),
        .rd_a_data(rf_a),
        .rd_b_data(rf_b),
        .wr_en(w_wr),
        .wr_addr(w_dst),
        .wr_data(w_res)
    );

    product_quotient_unit #(.STYLE(PQ_STYLE)) pq (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .launch(e_go && e_is_pq),
        .op(e_op),
        .src_a(op_a),
        .src_b(op_b),
        .busy(pq_busy),
        .upper_product_register(pq_upper),
        .lower_product_register(pq_lower),
        .gpr_result_valid(pq_gpr_valid),
        .gpr_result(pq_gpr)
    );
endmodule

// >>> verification/five_stage_core_pipeline_props.sv
// Port-level checks for the five-stage pipeline.
// Assumes one core clock; the bind below attaches it to every pipeline.
`include "core_pipe_consts.vh"
`timescale 1ns/1ps
module core_pipe_props #(
    parameter SHADOW_BITS = 0,
    parameter [31:0] RESET_PC = 32'h0000_0000
) (
    input wire core_clk,
    input wire reset_n,
    input wire [SHADOW_BITS:0] shadow_set,
    input wire [31:0] instr_addr,
    input wire instr_req,
    input wire [31:0] instr_rdata,
    input wire [31:0] data_addr,
    input wire data_req,
    input wire data_we,
    input wire [31:0] data_wdata,
    input wire [31:0] data_rdata,
    input wire [31:0] break_value,
    input wire break_enable,
    input wire break_hit
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset and fetch start
    a_reset_quiet: assert property (disable iff (1'b0)
        !reset_n |-> !instr_req && !data_req && !break_hit)
        else $error("outputs active during reset");
    a_fetch_start: assert property ($rose(reset_n) |-> !instr_req ##[1:3] instr_req)
        else $error("fetch did not start after reset");
    a_fetch_hold: assert property (instr_req |=> instr_req)
        else $error("fetch request dropped");
    a_reset_pc: assert property ($rose(instr_req) |-> instr_addr == (RESET_PC & `MAP_MASK))
        else $error("first fetch not at reset address");

    ////////////////////////////////////////////////////////////////////////////////
    // Address mapping and access qualification
    a_fetch_mapped: assert property (instr_req |-> (instr_addr & ~`MAP_MASK) == 32'h0
        && instr_addr[1:0] == 2'b00)
        else $error("fetch address not mapped");
    a_data_mapped: assert property (data_req |-> (data_addr & ~`MAP_MASK) == 32'h0)
        else $error("data address not mapped");
    a_store_qualified: assert property (data_we |-> data_req)
        else $error("write strobe without request");
    a_break_cause: assert property (break_hit |-> $past(break_enable))
        else $error("break hit while compare disabled");

    // Main scenarios
    c_store: cover property (data_req && data_we);
    c_load: cover property (data_req && !data_we);
    c_break: cover property (break_hit);
endmodule

bind five_stage_core_pipeline core_pipe_props #(
    .SHADOW_BITS(SHADOW_BITS),
    .RESET_PC(RESET_PC)
) u_props (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .shadow_set(shadow_set),
    .instr_addr(instr_addr),
    .instr_req(instr_req),
    .instr_rdata(instr_rdata),
    .data_addr(data_addr),
    .data_req(data_req),
    .data_we(data_we),
    .data_wdata(data_wdata),
    .data_rdata(data_rdata),
    .break_value(break_value),
    .break_enable(break_enable),
    .break_hit(break_hit)
);

// >>> verification/sram_partner.sv
// Instruction and data SRAM model for the pipeline's far side.
// Assumes answers one clock after the request; idle outputs are scrambled.
`timescale 1ns/1ps
module sram_partner (
    input wire core_clk,
    input wire [31:0] instr_addr,
    input wire instr_req,
    output logic [31:0] instr_rdata,
    input wire [31:0] data_addr,
    input wire data_req,
    input wire data_we,
    input wire [31:0] data_wdata,
    output logic [31:0] data_rdata
);
    logic [31:0] imem [0:63];
    logic [31:0] dmem [0:63];

    initial begin
        instr_rdata = 32'h0;
        data_rdata = 32'h0;
    end

    // Fetch answer next cycle, inverted when no request
    always @(posedge core_clk) begin
        if (instr_req === 1'b1)
            instr_rdata <= imem[instr_addr[7:2]];
        else
            instr_rdata <= ~instr_rdata;
    end

    // Store writes, load answers next cycle, stale data never held
    always @(posedge core_clk) begin
        if (data_req === 1'b1 && data_we === 1'b1)
            dmem[data_addr[7:2]] <= data_wdata;
        if (data_req === 1'b1 && data_we !== 1'b1)
            data_rdata <= dmem[data_addr[7:2]];
        else
            data_rdata <= ~data_rdata;
    end
endmodule

// >>> verification/five_stage_core_pipeline_tb.sv
// Self-checking bench: small programs of loads, ALU, product and stores.
// Assumes the SRAM model answers next cycle and register zero reads zero.
`include "core_pipe_consts.vh"
`timescale 1ns/1ps
module five_stage_core_pipeline_tb;
    localparam int SB = 1;
    localparam int LIMIT = 20000;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [SB:0] shadow_set = '0;
    logic [31:0] break_value = 32'h0;
    logic break_enable = 1'b0;
    wire [31:0] instr_addr, instr_rdata, data_addr, data_wdata, data_rdata;
    wire instr_req, data_req, data_we, break_hit;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    int hits = 0;
    logic [31:0] st_addr[$];
    logic [31:0] st_data[$];

    always #12.5 core_clk = ~core_clk;

    five_stage_core_pipeline #(.PQ_STYLE(1), .ISA_MODE(0), .SHADOW_BITS(SB)) DUT (
        .core_clk(core_clk), .reset_n(reset_n), .shadow_set(shadow_set),
        .instr_addr(instr_addr), .instr_req(instr_req), .instr_rdata(instr_rdata),
        .data_addr(data_addr), .data_req(data_req), .data_we(data_we),
        .data_wdata(data_wdata), .data_rdata(data_rdata), .break_value(break_value),
        .break_enable(break_enable), .break_hit(break_hit));

    sram_partner mem (
        .core_clk(core_clk), .instr_addr(instr_addr), .instr_req(instr_req),
        .instr_rdata(instr_rdata), .data_addr(data_addr), .data_req(data_req),
        .data_we(data_we), .data_wdata(data_wdata), .data_rdata(data_rdata));

    ////////////////////////////////////////////////////////////////////////////////
    // Store and break monitor, run-time ceiling
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (reset_n && data_req === 1'b1 && data_we === 1'b1) begin
            st_addr.push_back(data_addr);
            st_data.push_back(data_wdata);
        end
        if (break_hit === 1'b1)
            hits = hits + 1;
        if (cycles >= LIMIT) begin
            error_cnt = error_cnt + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (error_cnt == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction encoding and expected results
    function automatic logic [31:0] enc(input logic [3:0] op, input logic [4:0] d,
        input logic [4:0] a, input logic [4:0] b, input logic [12:0] imm);
        return {op, d, a, b, imm};
    endfunction

    function automatic logic [31:0] alu_exp(input logic [3:0] op, input logic [31:0] a,
        input logic [31:0] b);
        case (op)
            `OP_ADD: return a + b;
            `OP_SUB: return a - b;
            `OP_AND: return a & b;
            `OP_OR: return a | b;
            `OP_XOR: return a ^ b;
            default: return a * b;
        endcase
    endfunction

    // One program: two loads, dependent ops, multiply, divide, stores
    task automatic run_case(input logic [31:0] a, input logic [31:0] b, input logic brk);
        logic [3:0] ops[6];
        logic [31:0] exp[8];
        int n;
        int i;
        int h0;
        ops = '{`OP_ADD, `OP_SUB, `OP_AND, `OP_OR, `OP_XOR, `OP_MUL};
        reset_n = 1'b0;
        st_addr.delete();
        st_data.delete();
        for (i = 0; i < 64; i++)
            mem.imem[i] = 32'h0;
        mem.dmem[0] = a;
        mem.dmem[1] = b;
        mem.imem[0] = enc(`OP_LOAD, 5'd1, 5'd0, 5'd0, 13'h0);
        mem.imem[1] = enc(`OP_LOAD, 5'd2, 5'd0, 5'd0, 13'h4);
        n = 2;
        for (i = 0; i < 6; i++) begin
            mem.imem[n] = enc(ops[i], 5'd3, 5'd1, 5'd2, 13'h0);
            mem.imem[n + 1] = enc(`OP_STORE, 5'd0, 5'd0, 5'd3, 13'(8'h40 + 4 * i));
            exp[i] = alu_exp(ops[i], a, b);
            n += 2;
        end
        mem.imem[n] = enc(`OP_DIV, 5'd0, 5'd1, 5'd2, 13'h0);
        mem.imem[n + 1] = enc(`OP_MFLO, 5'd5, 5'd0, 5'd0, 13'h0);
        mem.imem[n + 2] = enc(`OP_STORE, 5'd0, 5'd0, 5'd5, 13'h58);
        mem.imem[n + 3] = enc(`OP_MFHI, 5'd6, 5'd0, 5'd0, 13'h0);
        mem.imem[n + 4] = enc(`OP_STORE, 5'd0, 5'd0, 5'd6, 13'h5c);
        exp[6] = (b == 32'h0) ? 32'hffff_ffff : a / b;
        exp[7] = (b == 32'h0) ? a : a % b;
        break_value = exp[0];
        break_enable = brk;
        shadow_set = (SB + 1)'($urandom);
        step(20);
        reset_n = 1'b1;
        h0 = hits;
        for (i = 0; i < 600 && st_addr.size() < 8; i++)
            step(1);
        step(6);
        check_word(32'(st_addr.size()), 32'd8);
        for (i = 0; i < 8; i++) begin
            check_word(st_addr[i], 32'h40 + 32'(4 * i));
            check_word(st_data[i], exp[i]);
        end
        check_bit(hits > h0, brk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Corner cases, then seeded random operands
    initial begin
        logic [31:0] r;
        logic [31:0] s;
        int k;
        r = $urandom(32'hbff0);
        step(1);
        run_case(32'h0000_1234, 32'h0, 1'b1);
        run_case(32'h7fff_ffff, 32'h1, 1'b0);
        run_case(32'h0000_0005, 32'h7fff_ffff, 1'b1);
        for (k = 0; k < 6; k++) begin
            r = $urandom;
            s = $urandom;
            run_case({1'b0, r[30:0]}, {1'b0, s[30:1], 1'b1}, s[0]);
        end
        print_verdict();
    end
endmodule
